// ---- core/hbm_host_port.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "hbm_map.svh"

// What this block does
// - Non-muxed address taken at chip select fall
// - Address lines select 32-bit words
// - Muxed mode: bit-2 line is latch strobe
// - Shared lines carry address, then data
// - Non-muxed mode: shared lines are data only
// - Muxed mode ignores dedicated bits 3 to 5
// - Three interrupt outputs, each event-set configurable
// - Chip select rise ends the cycle
// - Write-enable low writes, high reads
// - Data driven only while output enable low
module hbm_host_port (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic bus_mux_select_i,
  input wire logic host_cs_n_i,
  input wire logic host_oe_n_i,
  input wire logic host_we_n_i,
  input wire logic addr_bit2_or_latch_strobe_i,
  input wire logic addr_bit3_line_i,
  input wire logic addr_bit4_line_i,
  input wire logic addr_bit5_line_i,
  input wire hbm_pkg::hbm_word_type data_i,
  output hbm_pkg::hbm_word_type data_o,
  output logic data_oe_n_o,
  output logic rd_stb_o,
  output logic wr_stb_o,
  output hbm_pkg::hbm_waddr_type word_addr_o,
  output hbm_pkg::hbm_word_type wr_data_o,
  input wire hbm_pkg::hbm_word_type rd_data_i,
  input wire hbm_pkg::hbm_evt_type irq_event_i,
  input wire hbm_pkg::hbm_evt_type irq_route0_i,
  input wire hbm_pkg::hbm_evt_type irq_route1_i,
  input wire hbm_pkg::hbm_evt_type irq_route2_i,
  output logic host_irq_out_0_o,
  output logic host_irq_out_1_o,
  output logic host_irq_out_2_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // High when a sampled level went from one to zero
  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  hbm_pkg::hbm_pins_type raw; // Live pin levels
  hbm_pkg::hbm_pins_type s1_d, s1_q; // First stage, read by s2 only
  hbm_pkg::hbm_pins_type s2_d, s2_q; // Safe sampled levels
  hbm_pkg::hbm_pins_type s3_d, s3_q; // Previous safe levels

  // Gather the host pins
  always_comb begin
    raw.mux = bus_mux_select_i;
    raw.cs_n = host_cs_n_i;
    raw.oe_n = host_oe_n_i;
    raw.we_n = host_we_n_i;
    raw.a2_ale = addr_bit2_or_latch_strobe_i;
    raw.a3 = addr_bit3_line_i;
    raw.a4 = addr_bit4_line_i;
    raw.a5 = addr_bit5_line_i;
    raw.data = data_i;
  end

  // Shift chain: two stages, then one for edges
  always_comb begin
    s1_d = raw;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  // Register the chain; idle bus levels at reset
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      s1_q <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
      s2_q <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
      s3_q <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  // ----------------------------------------------------------------
  // Bus cycle control
  // ----------------------------------------------------------------
  logic mux_mode; // Multiplexed bus selected
  logic cs_fall; // Chip select went active
  logic cs_rise; // Chip select went inactive
  logic ale_fall; // Latch strobe closed
  hbm_pkg::hbm_state_type st_d, st_q; // Cycle phase
  hbm_pkg::hbm_waddr_type addr_d, addr_q; // Captured word address
  hbm_pkg::hbm_word_type wdat_d, wdat_q; // Write data to the core
  hbm_pkg::hbm_word_type rdat_d, rdat_q; // Read data to the pins
  logic rd_d, rd_q; // Read request pulse
  logic wr_d, wr_q; // Write request pulse
  logic pend_d, pend_q; // Read data due this cycle
  logic oen_d, oen_q; // Data pin output enable, low drives

  always_comb begin
    mux_mode = (s2_q.mux == `HBM_MODE_MUX);
    cs_fall = fell(s3_q.cs_n, s2_q.cs_n);
    cs_rise = fell(s2_q.cs_n, s3_q.cs_n);
    ale_fall = fell(s3_q.a2_ale, s2_q.a2_ale);
  end

  // Phase sequencing and request generation
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    rd_d = 1'b0;
    wr_d = 1'b0;
    case (st_q)
      // Wait for chip select
      hbm_pkg::ST_IDLE: begin
        if (cs_fall) begin
          if (mux_mode) begin
            // Address follows on the shared lines
            st_d = hbm_pkg::ST_ADDR;
          end else begin
            // Dedicated lines hold the word address
            addr_d = {s2_q.a5, s2_q.a4, s2_q.a3, s2_q.a2_ale};
            st_d = hbm_pkg::ST_DATA;
            rd_d = s2_q.we_n;
          end
        end
      end
      // Multiplexed address phase
      hbm_pkg::ST_ADDR: begin
        if (cs_rise) begin
          st_d = hbm_pkg::ST_IDLE;
        end else if (ale_fall) begin
          // Shared lines hold the address while the strobe closes
          addr_d = s2_q.data[`HBM_AD_MSB:`HBM_AD_LSB];
          st_d = hbm_pkg::ST_DATA;
          rd_d = s2_q.we_n;
        end
      end
      // Data phase, ends at chip select rise
      hbm_pkg::ST_DATA: begin
        if (cs_rise) begin
          st_d = hbm_pkg::ST_IDLE;
          wr_d = ~s2_q.we_n;
          wdat_d = s2_q.data;
        end
      end
      default: begin
        st_d = hbm_pkg::ST_IDLE;
      end
    endcase
    // Core returns read data one cycle after the request
    pend_d = rd_q;
    if (pend_q) begin
      rdat_d = rd_data_i;
    end
    // Drive only in a data phase with output enable low
    oen_d = ~(st_q == hbm_pkg::ST_DATA && !cs_rise && !s2_q.oe_n);
  end

  // Register the cycle state
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      st_q <= hbm_pkg::ST_IDLE;
      addr_q <= `HBM_WADDR_RST;
      wdat_q <= `HBM_WORD_RST;
      rdat_q <= `HBM_WORD_RST;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      pend_q <= 1'b0;
      oen_q <= 1'b1;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      pend_q <= pend_d;
      oen_q <= oen_d;
    end
  end

  assign data_o = rdat_q;
  assign data_oe_n_o = oen_q;
  assign rd_stb_o = rd_q;
  assign wr_stb_o = wr_q;
  assign word_addr_o = addr_q;
  assign wr_data_o = wdat_q;

  // ----------------------------------------------------------------
  // Host interrupts
  // ----------------------------------------------------------------
  hbm_pkg::hbm_irq_type irq; // Registered outputs of the router

  hbm_irq_route u_irq (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .evt_i(irq_event_i),
    .route0_i(irq_route0_i),
    .route1_i(irq_route1_i),
    .route2_i(irq_route2_i),
    .irq_o(irq)
  );

  assign host_irq_out_0_o = irq[0];
  assign host_irq_out_1_o = irq[1];
  assign host_irq_out_2_o = irq[2];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  chk_nmux_addr_take: assert property (
    st_q == hbm_pkg::ST_IDLE && cs_fall && !mux_mode |=>
      addr_q == $past({s2_q.a5, s2_q.a4, s2_q.a3, s2_q.a2_ale}))
    else $error("dedicated address not taken at chip select fall");

  chk_mux_addr_take: assert property (
    st_q == hbm_pkg::ST_ADDR && ale_fall && !cs_rise |=>
      addr_q == $past(s2_q.data[`HBM_AD_MSB:`HBM_AD_LSB]) &&
      st_q == hbm_pkg::ST_DATA)
    else $error("shared address not latched at strobe close");

  chk_mux_addr_hold: assert property (
    st_q == hbm_pkg::ST_ADDR && !ale_fall |=> $stable(addr_q))
    else $error("address changed without latch strobe");

  chk_drive_gate: assert property (
    !data_oe_n_o |-> $past(!s2_q.oe_n) &&
      $past(st_q) == hbm_pkg::ST_DATA)
    else $error("data driven without output enable");

  chk_cycle_end: assert property (
    cs_rise |=> data_oe_n_o && st_q == hbm_pkg::ST_IDLE)
    else $error("chip select rise did not end the cycle");

  chk_write_dir: assert property (
    wr_stb_o |-> $past(cs_rise) && !$past(s2_q.we_n) &&
      wr_data_o == $past(s2_q.data))
    else $error("write strobe without write cycle end");

  chk_read_dir: assert property (
    rd_stb_o |-> $past(s2_q.we_n) ##1 !rd_stb_o ##1
      data_o == $past(rd_data_i))
    else $error("read request or data return wrong");

  chk_irq_route: assert property (
    |(irq_event_i & irq_route1_i) |=> host_irq_out_1_o)
    else $error("routed event did not raise interrupt");

  chk_mux_strobe_only: assert property (
    mux_mode && st_q == hbm_pkg::ST_IDLE && cs_fall |=>
      st_q == hbm_pkg::ST_ADDR && !rd_stb_o)
    else $error("muxed cycle skipped the address phase");

  cov_nmux_read: cover property (
    rd_stb_o && !mux_mode ##[1:20] !data_oe_n_o);
  cov_mux_write: cover property (
    mux_mode && ale_fall ##[1:40] wr_stb_o);
  cov_irq_any: cover property (
    host_irq_out_0_o && host_irq_out_2_o);

endmodule

`default_nettype wire

// ---- pkg/hbm_map.svh ----
`ifndef HBM_MAP_SVH
`define HBM_MAP_SVH

// ----------------------------------------------------------------
// Widths of the host port
// ----------------------------------------------------------------
// Data bus width in bits
`define HBM_DATA_W 32
// Word address width, dedicated lines 2 to 5
`define HBM_WADDR_W 4
// Internal event count per interrupt output
`define HBM_EVT_W 8
// Number of interrupt outputs
`define HBM_IRQ_N 3

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
// Address bits carried on the shared lines in multiplexed mode
`define HBM_AD_LSB 2
`define HBM_AD_MSB 5

// ----------------------------------------------------------------
// Mode codes and reset values
// ----------------------------------------------------------------
// Bus select level for the multiplexed bus
`define HBM_MODE_MUX 1'b1
// Reset values
`define HBM_WORD_RST 32'h0000_0000
`define HBM_WADDR_RST 4'h0
`define HBM_EVT_RST 8'h00
`define HBM_IRQ_RST 3'h0

`endif

// ---- pkg/hbm_pkg.sv ----
`default_nettype none
`include "hbm_map.svh"

package hbm_pkg;

  // ----------------------------------------------------------------
  // Data types
  // ----------------------------------------------------------------
  // One bus word
  typedef logic [`HBM_DATA_W-1:0] hbm_word_type;
  // Word address, no byte bits below it
  typedef logic [`HBM_WADDR_W-1:0] hbm_waddr_type;
  // Event vector and one route mask
  typedef logic [`HBM_EVT_W-1:0] hbm_evt_type;
  // Interrupt output vector
  typedef logic [`HBM_IRQ_N-1:0] hbm_irq_type;

  // Host pin levels, all sampled together
  typedef struct packed {
    logic mux;
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic a2_ale;
    logic a3;
    logic a4;
    logic a5;
    hbm_word_type data;
  } hbm_pins_type;

  // Cycle phases of the host port
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DATA
  } hbm_state_type;

endpackage

`default_nettype wire

// ---- core/hbm_irq_route.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "hbm_map.svh"

// Routes internal events onto three host interrupt outputs
module hbm_irq_route (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire hbm_pkg::hbm_evt_type evt_i,
  input wire hbm_pkg::hbm_evt_type route0_i,
  input wire hbm_pkg::hbm_evt_type route1_i,
  input wire hbm_pkg::hbm_evt_type route2_i,
  output hbm_pkg::hbm_irq_type irq_o
);

  // ----------------------------------------------------------------
  // Output selection
  // ----------------------------------------------------------------
  hbm_pkg::hbm_irq_type irq_d; // Next interrupt levels
  hbm_pkg::hbm_irq_type irq_q; // Registered interrupt levels

  // Each output fires on any event of its own chosen set
  always_comb begin
    irq_d[0] = |(evt_i & route0_i);
    irq_d[1] = |(evt_i & route1_i);
    irq_d[2] = |(evt_i & route2_i);
  end

  // Register the levels
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      irq_q <= `HBM_IRQ_RST;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign irq_o = irq_q;

endmodule

`default_nettype wire

// ---- testbench/hbm_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Host bus master
// ----------------------------------------------------------------
// Drives the device pins one chip-select cycle at a time
module hbm_host_model (
  input wire logic sys_clk_i,
  input wire hbm_pkg::hbm_word_type data_i,
  output var hbm_pkg::hbm_pins_type pins_o,
  output var hbm_pkg::hbm_word_type got_o
);
  // Idle pins: nothing selected, bus released
  initial begin
    pins_o = '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
    got_o = '0;
  end

  // Waits a number of clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // One word transfer; a strobe that never rises drops the cycle
  task automatic xfer(input logic m, input logic wn,
    input hbm_pkg::hbm_waddr_type a, input hbm_pkg::hbm_word_type wd,
    input logic ale_on);
    @(posedge sys_clk_i);
    pins_o.mux <= m;
    pins_o.we_n <= wn;
    // Muxed mode: dedicated lines carry the wrong address
    {pins_o.a5, pins_o.a4, pins_o.a3} <= m ? ~a[3:1] : a[3:1];
    pins_o.a2_ale <= m ? 1'b0 : a[0];
    pins_o.data <= m ? {26'h0, a, 2'h0} : wd;
    tick(4);
    pins_o.cs_n <= 1'b0;
    pins_o.a2_ale <= m ? ale_on : a[0];
    tick(4);
    pins_o.a2_ale <= m ? 1'b0 : a[0];
    // Output enable waits until the read word has been loaded
    tick(6);
    // Reads release the bus, shown as the inverse of the last value
    pins_o.data <= wn ? ~pins_o.data : wd;
    pins_o.oe_n <= ~wn;
    tick(6);
    got_o <= data_i;
    pins_o.cs_n <= 1'b1;
    pins_o.oe_n <= 1'b1;
    tick(5);
  endtask
endmodule

`default_nettype wire

// ---- testbench/host_bus_address_mux_pins_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module host_bus_address_mux_pins_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic m;
    logic wn;
    logic [3:0] a;
    logic [31:0] d;
  } hbm_row_type;
  // Mode, direction, word address, write data
  localparam hbm_row_type ROWS [8] = '{
    '{1'b0, 1'b0, 4'h0, 32'hA5A5_0001}, '{1'b0, 1'b1, 4'h0, 32'h0},
    '{1'b0, 1'b0, 4'hF, 32'h1234_5678}, '{1'b0, 1'b1, 4'hF, 32'h0},
    '{1'b1, 1'b0, 4'h5, 32'hDEAD_BEEF}, '{1'b1, 1'b1, 4'hA, 32'h0},
    '{1'b1, 1'b0, 4'h9, 32'h0F0F_F0F0}, '{1'b1, 1'b1, 4'h6, 32'h0}};
  // Event patterns: single output, two outputs, masked
  localparam hbm_pkg::hbm_evt_type EVTS [6] = '{8'h01, 8'h02, 8'h04,
    8'h11, 8'h10, 8'h02};
  logic clk, nrst, data_oe_n, rd_stb, wr_stb, irq0, irq1, irq2;
  hbm_pkg::hbm_pins_type pins;
  hbm_pkg::hbm_word_type got, bus, data_o, wd, rd_data, cap_wd;
  hbm_pkg::hbm_waddr_type wa, cap_wa;
  hbm_pkg::hbm_evt_type evt, rt0, rt1, rt2;
  int n_errors = 0;
  int check_count = 0;
  int n_rd = 0;
  int n_wr = 0;
  int nr0, nw0;

  // Pin level: device wins only while it enables its drivers
  assign bus = data_oe_n ? pins.data : data_o;

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  hbm_host_model host_u (.sys_clk_i(clk), .data_i(bus), .pins_o(pins),
    .got_o(got));
  hbm_host_port dut_u (.sys_clk_i(clk), .nrst_i(nrst),
    .bus_mux_select_i(pins.mux), .host_cs_n_i(pins.cs_n),
    .host_oe_n_i(pins.oe_n), .host_we_n_i(pins.we_n),
    .addr_bit2_or_latch_strobe_i(pins.a2_ale),
    .addr_bit3_line_i(pins.a3), .addr_bit4_line_i(pins.a4),
    .addr_bit5_line_i(pins.a5), .data_i(bus), .data_o(data_o),
    .data_oe_n_o(data_oe_n), .rd_stb_o(rd_stb), .wr_stb_o(wr_stb),
    .word_addr_o(wa), .wr_data_o(wd), .rd_data_i(rd_data),
    .irq_event_i(evt), .irq_route0_i(rt0), .irq_route1_i(rt1),
    .irq_route2_i(rt2), .host_irq_out_0_o(irq0),
    .host_irq_out_1_o(irq1), .host_irq_out_2_o(irq2));

  // ----------------------------------------------------------------
  // Core side
  // ----------------------------------------------------------------
  // Clock at 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Core answers with the address repeated, one cycle after the strobe
  always @(posedge clk) begin
    rd_data <= {8{wa}};
    if (rd_stb === 1'b1) n_rd <= n_rd + 1;
    if (wr_stb === 1'b1) n_wr <= n_wr + 1;
    if (wr_stb === 1'b1) cap_wd <= wd;
    if ((rd_stb | wr_stb) === 1'b1) cap_wa <= wa;
  end

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Prints the verdict and stops
  task automatic end_sim();
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    #200000;
    n_errors++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    evt = '0;
    rt0 = '0;
    rt1 = '0;
    rt2 = '0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    // Outputs idle right after reset, bus released
    cmp32(data_o, 32'h0);
    cmp32({29'h0, data_oe_n, rd_stb, wr_stb}, 32'h4);
    // Ordinary cycles in both modes and directions
    foreach (ROWS[i]) begin
      nr0 = n_rd;
      nw0 = n_wr;
      host_u.xfer(ROWS[i].m, ROWS[i].wn, ROWS[i].a, ROWS[i].d, 1'b1);
      #1;
      cmp32({28'h0, cap_wa}, {28'h0, ROWS[i].a});
      cmp32(32'(n_rd - nr0), {31'h0, ROWS[i].wn});
      cmp32(32'(n_wr - nw0), {31'h0, ~ROWS[i].wn});
      if (ROWS[i].wn)
        cmp32(got, {8{ROWS[i].a}});
      else
        cmp32(cap_wd, ROWS[i].d);
      cmp32({31'h0, data_oe_n}, 32'h1);
    end
    // Muxed cycle with no latch strobe is dropped
    nr0 = n_rd;
    nw0 = n_wr;
    host_u.xfer(1'b1, 1'b0, 4'h3, 32'h5555_AAAA, 1'b0);
    cmp32(32'(n_rd + n_wr - nr0 - nw0), 32'h0);
    cmp32({28'h0, wa}, {28'h0, ROWS[7].a});
    // Interrupt routing, then masking of output 1
    @(posedge clk);
    rt0 <= 8'h01;
    rt1 <= 8'h06;
    rt2 <= 8'hF0;
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      evt <= EVTS[k];
      if (k == 5) rt1 <= 8'h00;
      repeat (3) @(posedge clk);
      #1;
      cmp32({29'h0, irq2, irq1, irq0}, {29'h0, |(evt & rt2),
        |(evt & rt1), |(evt & rt0)});
    end
    // Mid-run reset clears the outputs although an event stands
    @(posedge clk);
    evt <= 8'h01;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    cmp32({28'h0, wa}, 32'h0);
    cmp32(data_o, 32'h0);
    cmp32({28'h0, data_oe_n, irq2, irq1, irq0}, 32'h8);
    @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    // Routed event comes back one edge after release
    cmp32({29'h0, irq2, irq1, irq0}, 32'h1);
    end_sim();
  end
endmodule

`default_nettype wire
